//--- core/ceils_pkg.sv
// Purpose: Shared types and constants of the sideband control block
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Pin polarities are active high inside the block
package ceils_pkg;

  localparam int SYNC_STAGES = 2;
  localparam logic RST_ERR = 1'b0;
  localparam logic RST_LAPIC_EN = 1'b1;
  localparam logic RST_NE_BIT = 1'b0;

  typedef enum logic [1:0] {
    CEILS_RUN,
    CEILS_INIT,
    CEILS_SELFTEST
  } ceils_mode_type;

  // Asynchronous sideband inputs in pin order
  typedef struct packed {
    logic ignore_numeric_error_in;
    logic soft_init;
    logic [1:0] local_interrupt_pins;
    logic probe_request;
    logic stop_clock_request;
    logic bus_initialise;
  } ceils_async_type;

  localparam int ASYNC_W = $bits(ceils_async_type);

  typedef struct packed {
    ceils_async_type sync1;
    ceils_async_type sync2;
    logic internal_error_out;
    logic shutdown_req;
    logic fp_err_pending;
    logic fp_exception;
    logic lapic_en;
    logic numeric_error_enable_bit;
    logic prev_reset;
    logic selftest_req;
    logic integer_reset;
    logic atomic_lock;
    logic probe_ready;
    logic break_event;
    ceils_mode_type mode;
  } ceils_state_type;

endpackage : ceils_pkg

//--- core/ceils_sideband.sv
// Purpose: Error, init, interrupt fallback, lock and probe sideband logic
// Assumes: Async pins enter through two-stage synchronisers
// Notes: Core execution and bus phases are outside this block
// Notes: Register outputs follow a pin change three edges later
// Notes: Synchronisers keep sampling while hard reset is held
`timescale 1ns/1ps
`default_nettype none
module ceils_sideband (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire ceils_pkg::ceils_async_type async_i,
  input wire logic internal_fault_i,
  input wire logic fp_error_i,
  input wire logic fp_noncontrol_i,
  input wire logic fp_error_clear_i,
  input wire logic cfg_write_i,
  input wire logic cfg_lapic_en_i,
  input wire logic cfg_ne_bit_i,
  input wire logic lock_start_i,
  input wire logic lock_end_i,
  input wire logic debug_ready_i,
  input wire logic snoop_req_i,
  output logic internal_error_out_o,
  output logic shutdown_req_o,
  output logic fp_exception_o,
  output logic integer_reset_o,
  output logic selftest_req_o,
  output logic snoop_ack_o,
  output logic maskable_interrupt_request_o,
  output logic nonmaskable_interrupt_o,
  output logic [1:0] local_interrupt_o,
  output logic atomic_lock_o,
  output logic probe_ready_o,
  output logic break_event_o,
  output logic lapic_en_o,
  output logic numeric_error_enable_bit_o
);

  ceils_pkg::ceils_state_type state;
  ceils_pkg::ceils_state_type next_state;
  logic init_rise;
  logic ignore_active;
  logic error_clear;
  logic fp_trap;

  // Fallback pin when controller disabled
  function automatic logic fallback_pin(input logic ctrl_en, input logic pin);
    fallback_pin = !ctrl_en && pin;
  endfunction : fallback_pin

  // Local interrupt pin while controller enabled
  function automatic logic local_pin(input logic ctrl_en, input logic pin);
    local_pin = ctrl_en && pin;
  endfunction : local_pin

  // Mode entered at reset release
  function automatic ceils_pkg::ceils_mode_type release_mode(input logic init_seen);
    if (init_seen) begin
      release_mode = ceils_pkg::CEILS_SELFTEST;
    end else begin
      release_mode = ceils_pkg::CEILS_RUN;
    end
  endfunction : release_mode

  // New soft init only counts outside init
  assign init_rise = state.sync2.soft_init && (state.mode != ceils_pkg::CEILS_INIT);
  // Ignore input only counts while numeric enable clear
  assign ignore_active = state.sync2.ignore_numeric_error_in && !state.numeric_error_enable_bit;
  // Bus or soft init ends a held error
  assign error_clear = state.sync2.bus_initialise || state.sync2.soft_init;
  // Noncontrol instruction meets unignored pending error
  assign fp_trap = fp_noncontrol_i && state.fp_err_pending && !ignore_active;

  always_comb begin
    next_state = state;
    // Two-stage synchroniser
    next_state.sync1 = async_i;
    next_state.sync2 = state.sync1;
    // One-cycle pulses drop by default
    next_state.prev_reset = 1'b0;
    next_state.shutdown_req = 1'b0;
    next_state.fp_exception = 1'b0;
    next_state.integer_reset = 1'b0;
    next_state.selftest_req = 1'b0;
    // Configuration write
    if (cfg_write_i) begin
      next_state.lapic_en = cfg_lapic_en_i;
      next_state.numeric_error_enable_bit = cfg_ne_bit_i;
    end
    // Internal error, cleared by bus or soft init
    if (error_clear) begin
      next_state.internal_error_out = 1'b0;
    end else if (internal_fault_i && !state.internal_error_out) begin
      next_state.internal_error_out = 1'b1;
      next_state.shutdown_req = 1'b1;
    end
    // Numeric error tracking, new error wins over clear
    if (fp_error_i) begin
      next_state.fp_err_pending = 1'b1;
    end else if (fp_error_clear_i) begin
      next_state.fp_err_pending = 1'b0;
    end
    if (fp_trap) begin
      next_state.fp_exception = 1'b1;
    end
    // Pending error stays pending while ignored
    // Mode machine
    case (state.mode)
      ceils_pkg::CEILS_RUN: begin
        if (init_rise) begin
          next_state.mode = ceils_pkg::CEILS_INIT;
          next_state.integer_reset = 1'b1;
        end
      end
      ceils_pkg::CEILS_INIT: begin
        // Back to run mode once soft init releases
        if (!state.sync2.soft_init) begin
          next_state.mode = ceils_pkg::CEILS_RUN;
        end
      end
      ceils_pkg::CEILS_SELFTEST: begin
        next_state.mode = ceils_pkg::CEILS_RUN;
      end
      default: begin
        next_state.mode = ceils_pkg::CEILS_RUN;
      end
    endcase
    // Sample soft init at reset release
    if (state.prev_reset) begin
      next_state.selftest_req = state.sync2.soft_init;
      next_state.mode = release_mode(state.sync2.soft_init);
    end
    // Lock from first to last transaction
    if (lock_start_i) begin
      next_state.atomic_lock = 1'b1;
    end else if (lock_end_i) begin
      next_state.atomic_lock = 1'b0;
    end
    // Debug readiness from the core
    next_state.probe_ready = debug_ready_i;
    // Break event held until stop clock drops
    if (!state.sync2.stop_clock_request) begin
      next_state.break_event = 1'b0;
    end else if (state.sync2.probe_request) begin
      next_state.break_event = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= '0;
      // Sync chain keeps running so soft init is seen at release
      state.sync1 <= async_i;
      state.sync2 <= state.sync1;
      state.internal_error_out <= ceils_pkg::RST_ERR;
      state.shutdown_req <= 1'b0;
      state.fp_err_pending <= 1'b0;
      state.fp_exception <= 1'b0;
      state.selftest_req <= 1'b0;
      state.integer_reset <= 1'b0;
      state.atomic_lock <= 1'b0;
      state.probe_ready <= 1'b0;
      state.break_event <= 1'b0;
      state.lapic_en <= ceils_pkg::RST_LAPIC_EN;
      state.numeric_error_enable_bit <= ceils_pkg::RST_NE_BIT;
      state.prev_reset <= 1'b1;
      state.mode <= ceils_pkg::CEILS_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Register-fed outputs
  assign internal_error_out_o = state.internal_error_out;
  assign shutdown_req_o = state.shutdown_req;
  assign fp_exception_o = state.fp_exception;
  assign integer_reset_o = state.integer_reset;
  assign selftest_req_o = state.selftest_req;
  // Snoops answered also during soft init
  assign snoop_ack_o = snoop_req_i;
  // Pin fallback when controller disabled
  assign maskable_interrupt_request_o = fallback_pin(state.lapic_en,
    state.sync2.local_interrupt_pins[0]);
  assign nonmaskable_interrupt_o = fallback_pin(state.lapic_en,
    state.sync2.local_interrupt_pins[1]);
  // Local interrupt pins while controller enabled
  assign local_interrupt_o[0] = local_pin(state.lapic_en, state.sync2.local_interrupt_pins[0]);
  assign local_interrupt_o[1] = local_pin(state.lapic_en, state.sync2.local_interrupt_pins[1]);
  assign atomic_lock_o = state.atomic_lock;
  assign probe_ready_o = state.probe_ready;
  assign break_event_o = state.break_event;
  assign lapic_en_o = state.lapic_en;
  assign numeric_error_enable_bit_o = state.numeric_error_enable_bit;

endmodule : ceils_sideband
`default_nettype wire

//--- tb/ceils_far.sv
// Purpose: Far-side logic that drives the sideband pins
// Assumes: The bench asks for pin levels at clock edges
// Notes: Pins follow the request one clock later
`timescale 1ns/1ps
`default_nettype none
module ceils_far (
  input wire logic clk_i,
  input wire ceils_pkg::ceils_async_type want_i,
  output var ceils_pkg::ceils_async_type pins_o
);
  // Levels held steady around edges; init held over reset release
  always_ff @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule : ceils_far
`default_nettype wire

//--- tb/ceils_checker.sv
// Purpose: Port assertions of the sideband block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every sideband instance
`timescale 1ns/1ps
`default_nettype none
module ceils_checker (
  input wire logic sys_clk_i, rst_i, fp_noncontrol_i, lock_start_i, lock_end_i,
  input wire ceils_pkg::ceils_async_type async_i,
  input wire logic internal_error_out_o, shutdown_req_o, fp_exception_o, lapic_en_o,
  input wire logic numeric_error_enable_bit_o, maskable_interrupt_request_o,
  input wire logic nonmaskable_interrupt_o, atomic_lock_o, break_event_o, selftest_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  shut_pulse_a: assert property (shutdown_req_o == $rose(internal_error_out_o))
    else $error("shutdown pulse wrong");
  err_hold_a: assert property (internal_error_out_o && !$past(async_i.soft_init, 2)
    && !$past(async_i.bus_initialise, 2) |=> internal_error_out_o) else $error("error lost");
  fp_ignore_a: assert property (fp_noncontrol_i && !numeric_error_enable_bit_o
    && $past(async_i.ignore_numeric_error_in, 2) |=> !fp_exception_o) else $error("fp exc");
  maskable_interrupt_request_map_a: assert property (!lapic_en_o |-> {nonmaskable_interrupt_o,
    maskable_interrupt_request_o} == $past(async_i.local_interrupt_pins, 2)) else $error("map");
  lint_reset_a: assert property ($fell(rst_i) |-> lapic_en_o && !atomic_lock_o)
    else $error("reset state");
  lock_set_a: assert property (lock_start_i |=> atomic_lock_o)
    else $error("lock not set");
  lock_drop_a: assert property (lock_end_i && !lock_start_i |=> !atomic_lock_o)
    else $error("lock held");
  break_flag_a: assert property ($past(async_i.probe_request, 2)
    && $past(async_i.stop_clock_request, 2) |=> break_event_o) else $error("no break");
  self_test_a: assert property ($fell(rst_i) && async_i.soft_init
    |-> ##[1:3] selftest_req_o) else $error("no self-test");
  cover property (shutdown_req_o);
  cover property (fp_exception_o);
  cover property (break_event_o);
endmodule : ceils_checker
bind ceils_sideband ceils_checker chk (.*);
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Directed bench of the sideband block
// Assumes: 10 MHz clock, reset held 3 cycles
// Notes: Pins pass the far model, then two sync flops
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin err_count++; \
  $display("unexpected %0t compare mismatch",$time); end end
module testbench;
  logic sys_clk_i=0,rst_i=1,internal_fault_i=0,fp_error_i=0,fp_noncontrol_i=0;
  logic fp_error_clear_i=0,cfg_write_i=0,cfg_lapic_en_i=1,cfg_ne_bit_i=0;
  logic lock_start_i=0,lock_end_i=0,debug_ready_i=0,snoop_req_i=0,shutdown_req_o;
  logic internal_error_out_o,fp_exception_o,integer_reset_o,selftest_req_o,snoop_ack_o;
  logic maskable_interrupt_request_o,nonmaskable_interrupt_o,atomic_lock_o,probe_ready_o;
  logic break_event_o,lapic_en_o,numeric_error_enable_bit_o;
  logic [1:0] local_interrupt_o;
  ceils_pkg::ceils_async_type async_i,want=7'h20;
  int err_count=0,n_checks=0;
  always #50 sys_clk_i=~sys_clk_i;
  ceils_far far (.clk_i(sys_clk_i),.want_i(want),.pins_o(async_i));
  ceils_sideband dut (.*);
  task automatic tick(int n); repeat (n) @(posedge sys_clk_i); endtask : tick
  task automatic final_report;
    $display("checks %0d errors %0d",n_checks,err_count);
    if (err_count==0 && n_checks>0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic t_err;
    tick(1); internal_fault_i<=1; snoop_req_i<=1;
    tick(1); internal_fault_i<=0;
    #1 `CHK({internal_error_out_o,shutdown_req_o},2'h3)
    tick(3); #1 `CHK({internal_error_out_o,shutdown_req_o},2'h2)
    tick(1); want.soft_init<=1; tick(4);
    #1 `CHK(integer_reset_o,1'h1)
    tick(1);
    #1 `CHK({internal_error_out_o,snoop_ack_o},2'h1)
    tick(1); want.soft_init<=0; tick(5);
  endtask : t_err
  task automatic t_fp;
    logic [2:0] tbl [3]='{3'h4,3'h1,3'h7}; // Ignore, enable bit, exception
    tick(1); fp_error_i<=1;
    foreach (tbl[k]) begin
      tick(1); fp_error_i<=0; cfg_write_i<=1; cfg_ne_bit_i<=tbl[k][1];
      want.ignore_numeric_error_in<=tbl[k][2];
      tick(1); cfg_write_i<=0; tick(4); fp_noncontrol_i<=1;
      tick(1); fp_noncontrol_i<=0; #1 `CHK(fp_exception_o,tbl[k][0])
    end
    `CHK(numeric_error_enable_bit_o,1'h1)
    tick(1); fp_error_clear_i<=1;
    tick(1); fp_error_clear_i<=0; fp_noncontrol_i<=1;
    tick(1); fp_noncontrol_i<=0; #1 `CHK(fp_exception_o,1'h0)
  endtask : t_fp
  task automatic t_int;
    tick(1); want.local_interrupt_pins<=2'h1; tick(5);
    #1 `CHK({local_interrupt_o,maskable_interrupt_request_o},3'h2)
    tick(1); cfg_write_i<=1; cfg_lapic_en_i<=0; tick(1); cfg_write_i<=0;
    #1 `CHK(lapic_en_o,1'h0)
    for (int p=1; p<3; p++) begin
      want.local_interrupt_pins<=p[1:0]; tick(5);
      #1 `CHK({local_interrupt_o,nonmaskable_interrupt_o,maskable_interrupt_request_o},4'(p))
      tick(1);
    end
  endtask : t_int
  task automatic t_lock;
    tick(1); lock_start_i<=1; tick(1); lock_start_i<=0; tick(3); lock_end_i<=1;
    #1 `CHK(atomic_lock_o,1'h1)
    tick(1); lock_end_i<=0; #1 `CHK(atomic_lock_o,1'h0)
    for (int w=0; w<8 && atomic_lock_o; w++) tick(1);
    `CHK(atomic_lock_o,1'h0)
  endtask : t_lock
  task automatic t_dbg;
    tick(1); debug_ready_i<=1; want.stop_clock_request<=1; want.probe_request<=1;
    tick(1); #1 `CHK(probe_ready_o,1'h1)
    tick(4); want.probe_request<=0; #1 `CHK(break_event_o,1'h1)
    tick(4); want.stop_clock_request<=0; #1 `CHK(break_event_o,1'h1)
    tick(5); #1 `CHK(break_event_o,1'h0)
  endtask : t_dbg
  initial begin
    logic hit;
    hit=0;
    tick(3); rst_i<=0;
    for (int i=0; i<4; i++) begin
      tick(1); #1 hit|=(selftest_req_o===1'h1);
    end
    `CHK(hit,1'h1)
    tick(1); want.soft_init<=0; tick(5);
    t_err(); t_fp(); t_int(); t_lock(); t_dbg();
    final_report();
  end
endmodule : testbench
`default_nettype wire
